// ===== rtcw_regs.vh
/*
 real-time clock constants: prescaler, counter moduli, field widths,
 reset values and periodic tick select bit positions.
 assumes: included by rtcw_top, rtcw_monitor and the bench.
*/
`ifndef RTCW_REGS_VH
`define RTCW_REGS_VH

// ------------------------------------------------------------
// tick source
// ------------------------------------------------------------
`define RTCW_XTAL_HZ        32768
`define RTCW_TICK_HZ        1
`define RTCW_PRESCALE       (`RTCW_XTAL_HZ / `RTCW_TICK_HZ)
`define RTCW_PRE_W          15

// ------------------------------------------------------------
// counter moduli and widths
// ------------------------------------------------------------
`define RTCW_SEC_MOD        60
`define RTCW_MIN_MOD        60
`define RTCW_HOUR_MOD       24
`define RTCW_DAY_MOD        32768
`define RTCW_SEC_W          6
`define RTCW_MIN_W          6
`define RTCW_HOUR_W         5
`define RTCW_DAY_W          15
`define RTCW_SW_W           16

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RTCW_SEC_RST        6'h00
`define RTCW_MIN_RST        6'h00
`define RTCW_HOUR_RST       5'h00
`define RTCW_DAY_RST        15'h0000

// ------------------------------------------------------------
// periodic tick select bit positions
// ------------------------------------------------------------
`define RTCW_PSEL_SEC       0
`define RTCW_PSEL_MIN       1
`define RTCW_PSEL_HOUR      2
`define RTCW_PSEL_DAY       3

`endif

// ===== rtcw_cnt.v
/*
 one wrapping counter stage of the time chain.
 assumes: inc is a one-cycle pulse; load overrides counting.
*/
`timescale 1ns/1ps
`default_nettype none

module rtcw_cnt
#(
   parameter W   = 6,
   parameter MOD = 60
)
(
   // clock and reset
   input  wire         clk,
   input  wire         reset_n,
   // control
   input  wire         inc,
   input  wire         load,
   input  wire [W-1:0] load_val,
   // state
   output reg  [W-1:0] cnt_reg,
   output reg          carry_reg
);

   // cut the 32-bit modulus arithmetic down to the stage width on purpose
   localparam [31:0]  LAST_FULL = MOD - 1;
   localparam [W-1:0] LAST      = LAST_FULL[W-1:0];

   reg [W-1:0] cnt_next;

   always @*
   begin
      cnt_next = cnt_reg;
      if (load)
         cnt_next = (load_val > LAST) ? LAST : load_val;
      // R04 wrap and carry
      else if (inc)
         cnt_next = (cnt_reg == LAST) ? {W{1'b0}} : cnt_reg + 1'b1;
   end

   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         cnt_reg   <= {W{1'b0}};
         carry_reg <= 1'b0;
      end
      else
      begin
         cnt_reg   <= cnt_next;
         carry_reg <= inc && !load && (cnt_reg == LAST);
      end
   end

endmodule

`default_nettype wire

// ===== rtcw_sync.v
/*
 two flip-flop level synchroniser into the system clock domain.
 assumes: d is a level held for several destination cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module rtcw_sync
(
   // destination clock and reset
   input  wire clk,
   input  wire reset_n,
   // level in, level out
   input  wire d,
   output reg  q_reg
);

   reg meta_reg;

   // R16 two-stage crossing
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         meta_reg <= 1'b0;
         q_reg    <= 1'b0;
      end
      else
      begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// ===== rtcw_top.v
/*
 real-time clock: prescaler, second/minute/hour/day chain, two alarms,
 countdown stopwatch, periodic ticks and wake-up events.
 assumes: clk is the crystal-domain clock; the crystal rate arrives as
 xtal_tick, a one-cycle strobe per crystal period, so that all logic
 stays on one clock; sys_clk logic receives the synchronised outputs.
*/
// Contract
// R01 - prescale crystal down to one hertz tick
// R02 - sixty-state seconds and minutes counters
// R03 - twenty-four hours, 32768 days counters
// R04 - wrap to zero, carry to next unit
// R05 - enabled alarm fires on time match
// R06 - first alarm compares time of day only
// R07 - second alarm compares day and time
// R08 - stopwatch counts down once per second
// R09 - enabled stopwatch interrupts on underflow
// R10 - selectable second/minute/hour/day interrupts
// R11 - wake-up event exits sleep
// R12 - wake-up ends deep sleep, regulator on
// R13 - deep sleep wake goes to active
// R14 - no internal or memory access
// R15 - wake-up restarts regulator from hibernate
// R16 - synchronise outputs into system clock; only the irq and wake levels are synchronised, the other outputs stay on clk
`timescale 1ns/1ps
`default_nettype none
`include "rtcw_regs.vh"

module rtcw_top
#(
   parameter PRESCALE = `RTCW_PRESCALE,
   parameter SW_W     = `RTCW_SW_W
)
(
   // clock and reset
   input  wire                    clk,
   input  wire                    reset_n,
   input  wire                    sys_clk,
   input  wire                    sys_reset_n,
   // crystal rate strobe
   input  wire                    xtal_tick,
   // time load
   input  wire                    time_load,
   input  wire [`RTCW_SEC_W-1:0]  sec_in,
   input  wire [`RTCW_MIN_W-1:0]  min_in,
   input  wire [`RTCW_HOUR_W-1:0] hour_in,
   input  wire [`RTCW_DAY_W-1:0]  day_in,
   // alarm setting
   input  wire                    alarm0_en,
   input  wire                    alarm1_en,
   input  wire [`RTCW_SEC_W-1:0]  alarm_sec,
   input  wire [`RTCW_MIN_W-1:0]  alarm_min,
   input  wire [`RTCW_HOUR_W-1:0] alarm_hour,
   input  wire [`RTCW_DAY_W-1:0]  alarm_day,
   // stopwatch
   input  wire                    sw_en,
   input  wire                    sw_load,
   input  wire [SW_W-1:0]         sw_load_val,
   // periodic select, flag clear, wake enable
   input  wire [3:0]              per_sel,
   input  wire [5:0]              flag_clr,
   input  wire [5:0]              wake_en,
   // power state of the processor
   input  wire                    pm_sleep,
   input  wire                    pm_deep_sleep,
   input  wire                    pm_hibernate,
   // time and status
   output reg  [`RTCW_SEC_W-1:0]  sec_reg,
   output reg  [`RTCW_MIN_W-1:0]  min_reg,
   output reg  [`RTCW_HOUR_W-1:0] hour_reg,
   output reg  [`RTCW_DAY_W-1:0]  day_reg,
   output reg  [SW_W-1:0]         sw_cnt_reg,
   output reg  [5:0]              flags_reg,
   output reg                     tick_reg,
   // events toward the processor; irq_sys and wake_sys in the system clock domain, the rest on clk
   output wire                    irq_sys,
   output wire                    wake_sys,
   output reg                     wake_sleep_reg,
   output reg                     wake_deep_active_reg,
   output reg                     vreg_restart_reg,
   output reg                     mem_access_block_reg
);

   // ------------------------------------------------------------
   // prescaler
   // ------------------------------------------------------------
   localparam [31:0]            PRE_FULL = PRESCALE - 1;
   localparam [`RTCW_PRE_W-1:0] PRE_LAST = PRE_FULL[`RTCW_PRE_W-1:0];

   reg [`RTCW_PRE_W-1:0] pre_reg;
   wire                  sec_tick;

   // R01 divide crystal to 1 Hz
   assign sec_tick = xtal_tick && (pre_reg == PRE_LAST);

   always @(posedge clk)
   begin
      if (!reset_n)
         pre_reg <= {`RTCW_PRE_W{1'b0}};
      else if (time_load)
         pre_reg <= {`RTCW_PRE_W{1'b0}};
      else if (sec_tick)
         pre_reg <= {`RTCW_PRE_W{1'b0}};
      else if (xtal_tick)
         pre_reg <= pre_reg + 1'b1;
   end

   // ------------------------------------------------------------
   // time counter chain
   // ------------------------------------------------------------
   wire [`RTCW_SEC_W-1:0]  sec_w;
   wire [`RTCW_MIN_W-1:0]  min_w;
   wire [`RTCW_HOUR_W-1:0] hour_w;
   wire [`RTCW_DAY_W-1:0]  day_w;
   wire c_sec;
   wire c_min;
   wire c_hour;

   // R02 seconds stage
   rtcw_cnt #(.W(`RTCW_SEC_W), .MOD(`RTCW_SEC_MOD)) u_sec
   (
      .clk       (clk),
      .reset_n   (reset_n),
      .inc       (sec_tick),
      .load      (time_load),
      .load_val  (sec_in),
      .cnt_reg   (sec_w),
      .carry_reg (c_sec)
   );

   // R02 minutes stage
   rtcw_cnt #(.W(`RTCW_MIN_W), .MOD(`RTCW_MIN_MOD)) u_min
   (
      .clk       (clk),
      .reset_n   (reset_n),
      .inc       (c_sec),
      .load      (time_load),
      .load_val  (min_in),
      .cnt_reg   (min_w),
      .carry_reg (c_min)
   );

   // R03 hours stage
   rtcw_cnt #(.W(`RTCW_HOUR_W), .MOD(`RTCW_HOUR_MOD)) u_hour
   (
      .clk       (clk),
      .reset_n   (reset_n),
      .inc       (c_min),
      .load      (time_load),
      .load_val  (hour_in),
      .cnt_reg   (hour_w),
      .carry_reg (c_hour)
   );

   // R03 days stage, R04 wraps without carry out
   rtcw_cnt #(.W(`RTCW_DAY_W), .MOD(`RTCW_DAY_MOD)) u_day
   (
      .clk       (clk),
      .reset_n   (reset_n),
      .inc       (c_hour),
      .load      (time_load),
      .load_val  (day_in),
      .cnt_reg   (day_w),
      .carry_reg ()
   );

   // ------------------------------------------------------------
   // alarms, compared once the chain has settled after a tick
   // ------------------------------------------------------------
   reg  [3:0] settle_reg;
   wire       tod_match;
   wire       alarm0_hit;
   wire       alarm1_hit;

   // ripple carry takes three cycles to reach the day stage
   always @(posedge clk)
   begin
      if (!reset_n)
         settle_reg <= 4'h0;
      else
         settle_reg <= {settle_reg[2:0], sec_tick};
   end

   assign tod_match = (sec_w == alarm_sec) && (min_w == alarm_min) &&
                      (hour_w == alarm_hour);
   // R05 R06 time-of-day alarm
   assign alarm0_hit = settle_reg[3] && alarm0_en && tod_match;
   // R07 day and time alarm
   assign alarm1_hit = settle_reg[3] && alarm1_en && tod_match &&
                       (day_w == alarm_day);

   // ------------------------------------------------------------
   // stopwatch
   // ------------------------------------------------------------
   reg  [SW_W-1:0] sw_next;
   reg             sw_under;

   always @*
   begin
      sw_next  = sw_cnt_reg;
      sw_under = 1'b0;
      if (sw_load)
         sw_next = sw_load_val;
      // R08 one decrement per second
      else if (sw_en && sec_tick)
      begin
         sw_next = sw_cnt_reg - 1'b1;
         // R09 underflow past zero
         sw_under = (sw_cnt_reg == {SW_W{1'b0}});
      end
   end

   // ------------------------------------------------------------
   // sticky event flags
   // bit 0 sec, 1 min, 2 hour, 3 day, 4 alarms, 5 stopwatch
   // ------------------------------------------------------------
   reg  [5:0] ev;
   wire       any_flag;

   always @*
   begin
      // R10 selectable periodic ticks
      ev[`RTCW_PSEL_SEC]  = per_sel[`RTCW_PSEL_SEC]  && settle_reg[0];
      ev[`RTCW_PSEL_MIN]  = per_sel[`RTCW_PSEL_MIN]  && c_sec;
      ev[`RTCW_PSEL_HOUR] = per_sel[`RTCW_PSEL_HOUR] && c_min;
      ev[`RTCW_PSEL_DAY]  = per_sel[`RTCW_PSEL_DAY]  && c_hour;
      ev[4]               = alarm0_hit || alarm1_hit;
      ev[5]               = sw_under;
   end

   assign any_flag = |(flags_reg & wake_en);

   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         sec_reg    <= `RTCW_SEC_RST;
         min_reg    <= `RTCW_MIN_RST;
         hour_reg   <= `RTCW_HOUR_RST;
         day_reg    <= `RTCW_DAY_RST;
         sw_cnt_reg <= {SW_W{1'b0}};
         flags_reg  <= 6'h00;
         tick_reg   <= 1'b0;
      end
      else
      begin
         sec_reg    <= sec_w;
         min_reg    <= min_w;
         hour_reg   <= hour_w;
         day_reg    <= day_w;
         sw_cnt_reg <= sw_next;
         // set wins over a clear in the same cycle
         flags_reg  <= (flags_reg & ~flag_clr) | ev;
         tick_reg   <= sec_tick;
      end
   end

   // ------------------------------------------------------------
   // wake-up toward power management
   // ------------------------------------------------------------
   reg wake_lvl_reg;
   reg irq_lvl_reg;

   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         wake_lvl_reg         <= 1'b0;
         irq_lvl_reg          <= 1'b0;
         wake_sleep_reg       <= 1'b0;
         wake_deep_active_reg <= 1'b0;
         vreg_restart_reg     <= 1'b0;
         mem_access_block_reg <= 1'b0;
      end
      else
      begin
         wake_lvl_reg         <= any_flag;
         irq_lvl_reg          <= |flags_reg;
         // R11 leave sleep
         wake_sleep_reg       <= any_flag && pm_sleep;
         // R12 R13 deep sleep exit to active, regulator back on
         wake_deep_active_reg <= any_flag && pm_deep_sleep;
         // R12 R15 regulator restart request
         vreg_restart_reg     <= any_flag &&
                                 (pm_deep_sleep || pm_hibernate);
         // R14 no internal or memory access in deep sleep or hibernate
         mem_access_block_reg <= pm_deep_sleep || pm_hibernate;
      end
   end

   // ------------------------------------------------------------
   // crossing into the system clock
   // ------------------------------------------------------------
   // R16 interrupt level
   rtcw_sync u_sync_irq
   (
      .clk     (sys_clk),
      .reset_n (sys_reset_n),
      .d       (irq_lvl_reg),
      .q_reg   (irq_sys)
   );

   // R16 wake level
   rtcw_sync u_sync_wake
   (
      .clk     (sys_clk),
      .reset_n (sys_reset_n),
      .d       (wake_lvl_reg),
      .q_reg   (wake_sys)
   );

endmodule

`default_nettype wire

// ===== rtcw_monitor.sv
/*
 concurrent checks on the clock block's ports.
 assumes: bound to rtcw_top; all watched signals on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtcw_regs.vh"

module rtcw_monitor
#(
   parameter SW_W = 16
)
(
   // clock and reset
   input wire logic                    clk,
   input wire logic                    reset_n,
   // controls
   input wire logic                    time_load,
   input wire logic                    sw_load,
   input wire logic [3:0]              per_sel,
   input wire logic [5:0]              flag_clr,
   input wire logic                    pm_deep_sleep,
   input wire logic                    pm_hibernate,
   input wire logic                    alarm0_en,
   input wire logic                    alarm1_en,
   input wire logic [`RTCW_SEC_W-1:0]  alarm_sec,
   input wire logic [`RTCW_MIN_W-1:0]  alarm_min,
   input wire logic [`RTCW_HOUR_W-1:0] alarm_hour,
   input wire logic [`RTCW_DAY_W-1:0]  alarm_day,
   // state
   input wire logic [`RTCW_SEC_W-1:0]  sec_reg,
   input wire logic [`RTCW_MIN_W-1:0]  min_reg,
   input wire logic [`RTCW_HOUR_W-1:0] hour_reg,
   input wire logic [`RTCW_DAY_W-1:0]  day_reg,
   input wire logic [SW_W-1:0]         sw_cnt_reg,
   input wire logic [5:0]              flags_reg,
   input wire logic                    tick_reg,
   input wire logic                    mem_access_block_reg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // ----
   // time chain
   // ----
   // loads are excluded: they move the counters without a tick
   a_sec_step: assert property (tick_reg && !time_load && !$past(time_load) |=>
      sec_reg == (($past(sec_reg) == 6'h3B) ? 6'h00 : $past(sec_reg) + 6'h01))
      else $error("seconds did not step on tick");
   a_min_carry: assert property (!$stable(min_reg) && !$past(time_load) &&
      !$past(time_load, 2) |-> sec_reg == 6'h00)
      else $error("minutes moved without seconds wrap");
   a_hour_carry: assert property (!$stable(hour_reg) && !$past(time_load) &&
      !$past(time_load, 2) |-> min_reg == 6'h00)
      else $error("hours moved without minutes wrap");

   // ----
   // flags
   // ----
   a_flag_sticky: assert property ((($past(flags_reg) & ~$past(flag_clr)) &
      ~flags_reg) == 6'h00)
      else $error("flag dropped without clear");
   a_sec_flag: assert property (tick_reg && per_sel[0] |=> flags_reg[0])
      else $error("second flag not set");
   a_flag_cause: assert property ($rose(flags_reg[0]) |-> $past(tick_reg))
      else $error("second flag without tick");
   a_alarm_match: assert property ($rose(flags_reg[4]) |->
      (sec_reg == alarm_sec && min_reg == alarm_min && hour_reg == alarm_hour)
      && (alarm0_en || (alarm1_en && day_reg == alarm_day)))
      else $error("alarm flag without match");

   // ----
   // stopwatch and power
   // ----
   a_sw_step: assert property (!$stable(sw_cnt_reg) && !$past(sw_load) &&
      !$past(sw_load, 2) |-> sw_cnt_reg == $past(sw_cnt_reg) - 1'b1)
      else $error("stopwatch moved by other than one");
   a_sw_flag: assert property ($rose(flags_reg[5]) |->
      ##[0:1] sw_cnt_reg == {SW_W{1'b1}})
      else $error("stopwatch flag without underflow");
   a_mem_block: assert property ((pm_deep_sleep || pm_hibernate) [*2] |->
      mem_access_block_reg)
      else $error("memory access not blocked");

   c_tick: cover property (tick_reg);
   c_alarm: cover property ($rose(flags_reg[4]));
   c_sw: cover property ($rose(flags_reg[5]));
endmodule

bind rtcw_top rtcw_monitor #(.SW_W(SW_W)) i_rtcw_monitor (.clk, .reset_n,
   .time_load, .sw_load, .per_sel, .flag_clr, .pm_deep_sleep, .pm_hibernate,
   .alarm0_en, .alarm1_en, .alarm_sec, .alarm_min, .alarm_hour, .alarm_day,
   .sec_reg, .min_reg, .hour_reg, .day_reg, .sw_cnt_reg, .flags_reg,
   .tick_reg, .mem_access_block_reg);
`default_nettype wire

// ===== tb_rtcw_top.sv
/*
 self-checking bench for the clock block, random crystal strobes.
 assumes: rtcw_top and rtcw_monitor are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtcw_regs.vh"

module tb_rtcw_top;
   localparam PRE = 8;
   localparam logic [15:0] ALM = 16'hB650;
   // ----
   // signals
   // ----
   logic        clk, sys_clk, reset_n, xtal_tick, time_load;
   logic [5:0]  sec_in, min_in, alarm_sec, alarm_min, flag_clr, wake_en;
   logic [4:0]  hour_in, alarm_hour;
   logic [14:0] day_in, alarm_day;
   logic        alarm0_en, alarm1_en, sw_en, sw_load;
   logic [15:0] sw_load_val;
   logic [3:0]  per_sel, c;
   logic        pm_sleep, pm_deep_sleep, pm_hibernate;
   wire  [5:0]  sec_reg, min_reg, flags_reg;
   wire  [4:0]  hour_reg;
   wire  [14:0] day_reg;
   wire  [15:0] sw_cnt_reg;
   wire         tick_reg, irq_sys, wake_sys, w_sl, w_da, w_vr, w_mb;
   logic [31:0] t, a;
   int          miscompares, checks_done, ticks, cycles, i, n;

   rtcw_top #(.PRESCALE(PRE), .SW_W(16)) i_rtcw_top (.clk, .reset_n,
      .sys_clk, .sys_reset_n(reset_n), .xtal_tick, .time_load, .sec_in,
      .min_in, .hour_in, .day_in, .alarm0_en, .alarm1_en, .alarm_sec,
      .alarm_min, .alarm_hour, .alarm_day, .sw_en, .sw_load, .sw_load_val,
      .per_sel, .flag_clr, .wake_en, .pm_sleep, .pm_deep_sleep,
      .pm_hibernate, .sec_reg, .min_reg, .hour_reg, .day_reg, .sw_cnt_reg,
      .flags_reg, .tick_reg, .irq_sys, .wake_sys, .wake_sleep_reg(w_sl),
      .wake_deep_active_reg(w_da), .vreg_restart_reg(w_vr),
      .mem_access_block_reg(w_mb));

   initial forever #2.5 clk = ~clk;
   initial forever #3.5 sys_clk = ~sys_clk;

   // ----
   // helpers
   // ----
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (tick_reg === 1'b1)
         ticks <= ticks + 1;
      if (cycles == 20000)
      begin
         miscompares = miscompares + 1;
         wrap_up;
      end
   end

   function automatic logic [31:0] adv(input logic [31:0] v, input int k);
      longint s;
   begin
      s = ((v[31:17] * 64'd24 + v[16:12]) * 60 + v[11:6]) * 60 + v[5:0] + k;
      s = s % (64'd32768 * 86400);
      adv = {15'(s / 86400), 5'(s / 3600 % 24), 6'(s / 60 % 60), 6'(s % 60)};
   end
   endfunction

   task check(input string what, input logic [31:0] seen, exp);
   begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask

   // whole seconds only, so the prescaler stays aligned between runs
   task run(input int k);
      int m;
   begin
      m = 0;
      while (m < k * PRE)
      begin
         @(negedge clk);
         xtal_tick = 1'($urandom % 2);
         m = m + xtal_tick;
      end
      @(negedge clk);
      xtal_tick = 1'b0;
      repeat (12) @(negedge clk);
   end
   endtask

   task load(input logic [31:0] v);
   begin
      @(negedge clk);
      {day_in, hour_in, min_in, sec_in} = v;
      time_load = 1'b1;
      flag_clr = 6'h3F;
      @(negedge clk);
      time_load = 1'b0;
      flag_clr = 6'h00;
      repeat (3) @(negedge clk);
      ticks = 0;
   end
   endtask

   function automatic logic [31:0] rnd();
      rnd = {15'($urandom), 5'($urandom % 24), 6'($urandom % 60),
         6'($urandom % 60)};
   endfunction

   task wrap_up;
   begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask

   // ----
   // tests
   // ----
   initial
   begin
      {clk, sys_clk, reset_n, xtal_tick, time_load, sw_en, sw_load} = 7'h00;
      {sec_in, min_in, hour_in, day_in, alarm0_en, alarm1_en} = 34'h0;
      {alarm_sec, alarm_min, alarm_hour, alarm_day, sw_load_val} = 48'h0;
      {per_sel, flag_clr, wake_en, pm_sleep, pm_deep_sleep} = 18'h0;
      pm_hibernate = 1'b0;
      {miscompares, checks_done, ticks, cycles} = 128'h0;
      t = $urandom(28473);
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      check("reset time", {day_reg, hour_reg, min_reg, sec_reg}, 0);
      check("reset flags", flags_reg, 6'h00);
      for (i = 0; i < 3; i = i + 1)
      begin
         t = rnd();
         n = 1 + $urandom % 3;
         load(t);
         run(n);
         check("ticks", ticks, n);
         check("time", {day_reg, hour_reg, min_reg, sec_reg}, adv(t, n));
      end
      $display("end of counting test");
      per_sel = 4'hF;
      t = {15'h7FFF, 5'h17, 6'h3B, 6'h3A};
      load(t);
      run(2);
      check("wrap", {day_reg, hour_reg, min_reg, sec_reg}, adv(t, 2));
      check("tick flags", flags_reg, 6'h0F);
      per_sel = 4'h0;
      load(t);
      run(1);
      check("no flags", flags_reg, 6'h00);
      per_sel = 4'($urandom);
      load(t);
      run(2);
      check("sel flags", flags_reg, {2'h0, per_sel});
      per_sel = 4'h0;
      // out-of-range load values clamp to the last state of each stage
      load({15'h1234, 5'h1F, 6'h3F, 6'h3F});
      a = {15'h1234, 5'h17, 6'h3B, 6'h3B};
      check("clamp", {day_reg, hour_reg, min_reg, sec_reg}, a);
      $display("end of rollover test");
      for (i = 0; i < 4; i = i + 1)
      begin
         c = ALM[15 - 4 * i -: 4];
         t = rnd();
         a = adv(t, 2);
         {alarm_day, alarm_hour, alarm_min, alarm_sec} = a + {c[1], 17'h0};
         {alarm0_en, alarm1_en} = c[3:2];
         load(t);
         run(3);
         check("alarm", flags_reg[4], c[0]);
      end
      {alarm0_en, alarm1_en} = 2'h0;
      $display("end of alarm test");
      n = 2 + $urandom % 3;
      load(t);
      sw_load_val = 16'(n);
      sw_load = 1'b1;
      @(negedge clk);
      sw_load = 1'b0;
      sw_en = 1'b1;
      run(n);
      check("sw zero", sw_cnt_reg, 16'h0000);
      check("sw early", flags_reg[5], 1'b0);
      run(1);
      check("sw under", sw_cnt_reg, 16'hFFFF);
      check("sw flag", flags_reg[5], 1'b1);
      sw_en = 1'b0;
      run(1);
      check("sw hold", sw_cnt_reg, 16'hFFFF);
      $display("end of stopwatch test");
      wake_en = 6'h20;
      for (i = 0; i < 4; i = i + 1)
      begin
         {pm_sleep, pm_deep_sleep, pm_hibernate} = (i == 0) ? 3'h0 :
            3'h4 >> (i - 1);
         repeat (8) @(negedge clk);
         check("wake sleep", w_sl, i == 1);
         check("wake deep", w_da, i == 2);
         check("vreg", w_vr, i >= 2);
         check("mem block", w_mb, i >= 2);
         check("wake sys", wake_sys, 1'b1);
      end
      {pm_sleep, pm_deep_sleep, pm_hibernate} = 3'h4;
      wake_en = 6'h00;
      repeat (8) @(negedge clk);
      check("masked", w_sl, 1'b0);
      check("irq", irq_sys, 1'b1);
      flag_clr = 6'h3F;
      repeat (8) @(negedge clk);
      check("irq clear", irq_sys, 1'b0);
      $display("end of wake test");
      flag_clr = 6'h00;
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      check("mid reset", {day_reg, hour_reg, min_reg, sec_reg}, 0);
      check("mid reset sw", sw_cnt_reg, 16'h0000);
      run(1);
      check("restart", {day_reg, hour_reg, min_reg, sec_reg}, 1);
      $display("end of reset test");
      wrap_up;
   end
endmodule
`default_nettype wire
